/* File: ctb_pkg.sv */
// Constants, configuration and status types for the touch processing block.
package ctb_pkg;
    localparam int NSENS = 12;
    localparam int IDX_W = 4;
    localparam int TICK_W = 16;
    localparam int COMP_W = 16;
    localparam int SENS_W = 3;
    localparam int POS_W = 8;
    localparam int BIT_W = 4;
    localparam int PER_W = 16;
    localparam int AVG_SHIFT = 3;
    localparam logic [BIT_W-1:0] BIT_TOP = 4'hf;
    localparam logic [IDX_W-1:0] IDX_LAST = 4'hb;
    localparam logic [SENS_W-1:0] DEF_SENS = 3'h4;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_PICK = 3'h1,
        ST_CONV = 3'h3,
        ST_WAIT = 3'h2,
        ST_PROC = 3'h6,
        ST_SLD = 3'h7
    } ctb_state_t;

    typedef struct packed {
        logic [NSENS-1:0] sense_en;
        logic [NSENS-1:0] slider_mask;
        logic [NSENS-1:0] prox_mask;
        logic [NSENS-1:0][SENS_W-1:0] sens;
        logic [TICK_W-1:0] thr;
        logic [TICK_W-1:0] hys;
        logic [TICK_W-1:0] prox_thr;
        logic [TICK_W-1:0] prox_hys;
        logic [TICK_W-1:0] noise_pos;
        logic [TICK_W-1:0] noise_neg;
        logic [POS_W-1:0] slider_max;
        logic [POS_W-1:0] step;
        logic [PER_W-1:0] comp_period;
    } ctb_cfg_t;

    typedef struct packed {
        logic [NSENS-1:0] button_on;
        logic slider_on;
        logic [POS_W-1:0] slider_pos;
        logic move_high;
        logic move_low;
    } ctb_status_t;

    // Six buttons on inputs 0 to 5, one slider on inputs 6 to 11.
    localparam ctb_cfg_t CFG_DEFAULT = '{
        sense_en: 12'hfff,
        slider_mask: 12'hfc0,
        prox_mask: 12'h000,
        sens: {NSENS{DEF_SENS}},
        thr: 16'h0064,
        hys: 16'h000a,
        prox_thr: 16'h0020,
        prox_hys: 16'h0004,
        noise_pos: 16'h0040,
        noise_neg: 16'h0040,
        slider_max: 8'hff,
        step: 8'h04,
        comp_period: 16'h0000
    };
endpackage

/* File: ctb_proc.sv */
// Scan sequencer, tick filter, touch detection, slider and compensation.
`timescale 1ns/100ps
module ctb_proc #(
    parameter int AVG_SHIFT = ctb_pkg::AVG_SHIFT
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scan_start,
    input wire logic cfg_wr,
    input wire ctb_pkg::ctb_cfg_t cfg_in,
    input wire logic host_run,
    input wire logic host_comp_req,
    input wire logic irq_clear,
    output logic conv_start,
    output logic [ctb_pkg::IDX_W-1:0] conv_sel,
    output logic [ctb_pkg::SENS_W-1:0] conv_cycles,
    output logic [ctb_pkg::COMP_W-1:0] conv_comp,
    input wire logic conv_done,
    input wire logic signed [ctb_pkg::TICK_W-1:0] conv_ticks,
    output ctb_pkg::ctb_status_t status,
    output logic scan_done,
    output logic comp_done,
    output logic scan_busy,
    output logic irq_out_n
);
    localparam int N = ctb_pkg::NSENS;
    localparam int TW = ctb_pkg::TICK_W;
    localparam int CW = ctb_pkg::COMP_W;
    localparam int IW = ctb_pkg::IDX_W;

    ctb_pkg::ctb_state_t state;
    ctb_pkg::ctb_cfg_t cfg;
    logic [IW-1:0] idx;
    logic [ctb_pkg::BIT_W-1:0] bit_pos;
    logic comp_scan;
    logic comp_req;
    logic [ctb_pkg::PER_W-1:0] per_cnt;
    logic [CW-1:0] comp_work;
    logic [CW-1:0] trial;
    logic signed [TW-1:0] raw [N];
    logic [CW-1:0] comp_code [N];
    logic signed [TW:0] diff_w [N];
    logic [N-1:0] on_w;
    logic [N-1:0] noise_w;
    logic [IW:0] pick;
    logic proc_norm;
    logic per_hit;
    logic prev_on;
    logic [ctb_pkg::POS_W-1:0] prev_pos;
    logic [ctb_pkg::POS_W-1:0] next_pos;
    logic [ctb_pkg::POS_W:0] delta_up;
    logic [ctb_pkg::POS_W:0] delta_dn;

    // First enabled input at or above the given index, with a found flag.
    function automatic logic [IW:0] next_en(input logic [IW-1:0] from,
                                            input logic [N-1:0] en);
        logic [IW:0] res;
        res = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (en[i] && (i >= int'(from))) begin
                res = {1'b1, IW'(i)};
            end
        end
        return res;
    endfunction

    assign pick = next_en(idx, cfg.sense_en);
    assign trial = comp_work | (CW'(1) << bit_pos);
    assign proc_norm = (state == ctb_pkg::ST_PROC) && !comp_scan;
    assign per_hit = proc_norm && (cfg.comp_period != '0)
                     && (per_cnt == cfg.comp_period - 16'h0001);
    assign scan_busy = (state != ctb_pkg::ST_IDLE);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg <= ctb_pkg::CFG_DEFAULT;
        end else if (cfg_wr) begin
            cfg <= cfg_in;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            comp_req <= 1'b1;
        end else if ((proc_norm && (|noise_w)) || per_hit
                     || (host_comp_req && host_run)) begin
            comp_req <= 1'b1;
        end else if (state == ctb_pkg::ST_IDLE && scan_start) begin
            comp_req <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            per_cnt <= '0;
        end else if (per_hit || (comp_done && comp_scan)) begin
            per_cnt <= '0;
        end else if (proc_norm && cfg.comp_period != '0) begin
            per_cnt <= per_cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= ctb_pkg::ST_IDLE;
            idx <= '0;
            bit_pos <= ctb_pkg::BIT_TOP;
            comp_scan <= 1'b0;
            comp_work <= '0;
            conv_start <= 1'b0;
            conv_sel <= '0;
            conv_cycles <= '0;
            conv_comp <= '0;
        end else begin
            conv_start <= 1'b0;
            case (state)
                ctb_pkg::ST_IDLE: begin
                    if (scan_start) begin
                        comp_scan <= comp_req;
                        idx <= '0;
                        state <= ctb_pkg::ST_PICK;
                    end
                end
                ctb_pkg::ST_PICK: begin
                    if (pick[IW]) begin
                        idx <= pick[IW-1:0];
                        comp_work <= '0;
                        bit_pos <= ctb_pkg::BIT_TOP;
                        state <= ctb_pkg::ST_CONV;
                    end else begin
                        state <= ctb_pkg::ST_PROC;
                    end
                end
                ctb_pkg::ST_CONV: begin
                    conv_start <= 1'b1;
                    conv_sel <= idx;
                    conv_cycles <= cfg.sens[idx];
                    conv_comp <= comp_scan ? trial : comp_code[idx];
                    state <= ctb_pkg::ST_WAIT;
                end
                ctb_pkg::ST_WAIT: begin
                    if (conv_done && !conv_start) begin
                        if (comp_scan) begin
                            if (conv_ticks > 0) begin
                                comp_work <= trial;
                            end
                            if (bit_pos == '0) begin
                                idx <= (idx == ctb_pkg::IDX_LAST) ?
                                       idx : idx + 4'h1;
                                state <= (idx == ctb_pkg::IDX_LAST) ?
                                         ctb_pkg::ST_PROC : ctb_pkg::ST_PICK;
                            end else begin
                                bit_pos <= bit_pos - 4'h1;
                                state <= ctb_pkg::ST_CONV;
                            end
                        end else begin
                            idx <= (idx == ctb_pkg::IDX_LAST) ?
                                   idx : idx + 4'h1;
                            state <= (idx == ctb_pkg::IDX_LAST) ?
                                     ctb_pkg::ST_PROC : ctb_pkg::ST_PICK;
                        end
                    end
                end
                ctb_pkg::ST_PROC: begin
                    state <= comp_scan ? ctb_pkg::ST_IDLE : ctb_pkg::ST_SLD;
                end
                ctb_pkg::ST_SLD: begin
                    state <= ctb_pkg::ST_IDLE;
                end
                default: begin
                    state <= ctb_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Raw ticks and compensation codes, one entry per input.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < N; i++) begin
                raw[i] <= '0;
                comp_code[i] <= '0;
            end
        end else if (state == ctb_pkg::ST_WAIT && conv_done &&
                     !conv_start) begin
            if (!comp_scan) begin
                raw[idx] <= conv_ticks;
            end else if (bit_pos == '0) begin
                comp_code[idx] <= (conv_ticks > 0) ? trial : comp_work;
            end
        end
    end

    generate
        for (genvar g = 0; g < N; g++) begin : g_sens
            logic signed [TW-1:0] avg;
            logic signed [TW:0] diff;
            logic on;
            logic signed [TW:0] dlt;
            logic signed [TW-1:0] next_avg;
            logic signed [TW:0] next_diff;
            logic signed [TW+1:0] on_lvl;
            logic signed [TW+1:0] off_lvl;
            logic [TW-1:0] thr_g;
            logic [TW-1:0] hys_g;

            // proximity uses its own figures only
            assign thr_g = cfg.prox_mask[g] ? cfg.prox_thr : cfg.thr;
            assign hys_g = cfg.prox_mask[g] ? cfg.prox_hys : cfg.hys;
            assign on_lvl = $signed({2'b00, thr_g}) + $signed({2'b00, hys_g});
            assign off_lvl = $signed({2'b00, thr_g}) - $signed({2'b00, hys_g});
            assign dlt = (TW+1)'(raw[g]) - (TW+1)'(avg);
            assign next_avg = TW'(avg + TW'(dlt >>> AVG_SHIFT));
            assign next_diff = (TW+1)'(raw[g]) - (TW+1)'(next_avg);
            assign noise_w[g] = cfg.sense_en[g] &&
                ((next_avg > $signed({1'b0, cfg.noise_pos})) ||
                 ((TW+1)'(next_avg) < -$signed({1'b0, cfg.noise_neg})));
            assign diff_w[g] = diff;
            assign on_w[g] = on;

            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    avg <= '0;
                    diff <= '0;
                    on <= 1'b0;
                end else if (state == ctb_pkg::ST_PROC) begin
                    if (comp_scan || !cfg.sense_en[g]) begin
                        avg <= '0;
                        diff <= '0;
                        on <= on && cfg.sense_en[g];
                    end else begin
                        avg <= next_avg;
                        diff <= next_diff;
                        if ((TW+2)'(next_diff) >= on_lvl) begin
                            on <= 1'b1;
                        end else if ((TW+2)'(next_diff) < off_lvl) begin
                            on <= 1'b0;
                        end
                    end
                end
            end
        end
    endgenerate

    // centre of gravity over positive differences
    always_comb begin
        logic [31:0] num;
        logic [31:0] den;
        logic [31:0] cnt;
        logic [31:0] q;
        num = '0;
        den = '0;
        cnt = '0;
        q = '0;
        for (int i = 0; i < N; i++) begin
            if (cfg.slider_mask[i] && cfg.sense_en[i]) begin
                if (diff_w[i] > 0) begin
                    num = num + 32'(diff_w[i]) * cnt;
                    den = den + 32'(diff_w[i]);
                end
                cnt = cnt + 32'h1;
            end
        end
        if (den != '0 && cnt > 32'h1) begin
            q = (num * 32'(cfg.slider_max)) / (den * (cnt - 32'h1));
        end
        if (q > 32'(cfg.slider_max)) begin
            q = 32'(cfg.slider_max);
        end
        next_pos = ctb_pkg::POS_W'(q);
    end

    assign delta_up = {1'b0, next_pos} - {1'b0, prev_pos};
    assign delta_dn = {1'b0, prev_pos} - {1'b0, next_pos};

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            status <= '0;
            prev_on <= 1'b0;
            prev_pos <= '0;
            scan_done <= 1'b0;
        end else begin
            scan_done <= 1'b0;
            status.move_high <= 1'b0;
            status.move_low <= 1'b0;
            if (state == ctb_pkg::ST_SLD) begin
                scan_done <= 1'b1;
                status.button_on <= on_w;
                status.slider_on <= |(on_w & cfg.slider_mask);
                prev_on <= |(on_w & cfg.slider_mask);
                if (|(on_w & cfg.slider_mask)) begin
                    status.slider_pos <= next_pos;
                    prev_pos <= next_pos;
                    if (prev_on && delta_up[ctb_pkg::POS_W] == 1'b0 &&
                        delta_up[ctb_pkg::POS_W-1:0] >= cfg.step &&
                        next_pos != prev_pos) begin
                        status.move_high <= 1'b1;
                    end else if (prev_on && delta_dn[ctb_pkg::POS_W] == 1'b0 &&
                                 delta_dn[ctb_pkg::POS_W-1:0] >= cfg.step &&
                                 next_pos != prev_pos) begin
                        status.move_low <= 1'b1;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            comp_done <= 1'b0;
            irq_out_n <= 1'b1;
        end else begin
            comp_done <= (state == ctb_pkg::ST_PROC) && comp_scan;
            if ((state == ctb_pkg::ST_PROC) && comp_scan) begin
                irq_out_n <= 1'b0;
            end else if (irq_clear) begin
                irq_out_n <= 1'b1;
            end
        end
    end
endmodule // ctb_proc

/* File: ctb_chk.sv */
// Port checker for the touch processing block.
`timescale 1ns/100ps
module ctb_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scan_start,
    input wire logic irq_clear,
    input wire logic conv_start,
    input wire ctb_pkg::ctb_status_t status,
    input wire logic scan_done,
    input wire logic comp_done,
    input wire logic scan_busy,
    input wire logic irq_out_n
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_conv_single: assert property (
        conv_start |=> !conv_start) else $error("conv_start too long");
    a_conv_busy: assert property (
        conv_start |-> scan_busy) else $error("conversion outside scan");
    a_start_taken: assert property (
        scan_start && !scan_busy |=> scan_busy) else $error("scan not taken");
    a_done_idle: assert property (
        scan_done || comp_done |-> !scan_busy) else $error("busy at done");
    a_done_single: assert property (
        scan_done |=> !scan_done) else $error("scan_done too long");
    a_status_hold: assert property (
        !scan_done && !comp_done |-> $stable(status.button_on) &&
        $stable(status.slider_pos)) else $error("status changed off scan");
    a_move_done: assert property (
        status.move_high || status.move_low |-> scan_done && status.slider_on)
        else $error("move without scan or touch");
    a_move_excl: assert property (
        status.move_high |-> !status.move_low) else $error("both moves");
    a_irq_comp: assert property (
        comp_done |-> !irq_out_n) else $error("no irq at compensation");
    a_irq_hold: assert property (
        !irq_out_n && !irq_clear |=> !irq_out_n) else $error("irq dropped");

    c_comp: cover property (comp_done);
    c_high: cover property (status.move_high);
    c_low: cover property (status.move_low);
endmodule // ctb_chk

/* File: ctb_conv_model.sv */
// Behavioural charge converter answering the block's conversion requests.
`timescale 1ns/100ps
module ctb_conv_model (
    input wire logic clk,
    input wire logic slow,
    input wire logic [11:0][15:0] touch,
    input wire logic conv_start,
    input wire logic [ctb_pkg::IDX_W-1:0] conv_sel,
    input wire logic [ctb_pkg::COMP_W-1:0] conv_comp,
    output logic conv_done,
    output logic signed [ctb_pkg::TICK_W-1:0] conv_ticks
);
    logic [3:0] wait_cnt = 4'h0;
    logic [3:0] sel_q = 4'h0;
    logic [15:0] comp_q = 16'h0000;

    initial begin
        conv_done = 1'b0;
        conv_ticks = 16'h5a5a;
    end

    // Ticks fall as the code rises; outside the answer cycle they toggle.
    always @(posedge clk) begin
        conv_done <= 1'b0;
        conv_ticks <= ~conv_ticks;
        if (conv_start) begin
            wait_cnt <= slow ? 4'h6 : 4'h1;
            sel_q <= conv_sel;
            comp_q <= conv_comp;
        end else if (wait_cnt != 4'h0) begin
            wait_cnt <= wait_cnt - 4'h1;
            if (wait_cnt == 4'h1) begin
                conv_done <= 1'b1;
                conv_ticks <= 16'h0300 + {8'h00, sel_q, 4'h0} - comp_q
                    + touch[sel_q];
            end
        end
    end
endmodule // ctb_conv_model

/* File: tb.sv */
// Self-checking bench for the touch processing block.
`timescale 1ns/100ps
module tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic scan_start = 1'b0;
    logic cfg_wr = 1'b0;
    logic host_run = 1'b1;
    logic host_comp_req = 1'b0;
    logic irq_clear = 1'b0;
    logic slow = 1'b0;
    ctb_pkg::ctb_cfg_t cfg_in = ctb_pkg::CFG_DEFAULT;
    logic [11:0][15:0] touch = '0;
    logic conv_start, conv_done, scan_done, comp_done, scan_busy, irq_out_n;
    logic [ctb_pkg::IDX_W-1:0] conv_sel;
    logic [ctb_pkg::SENS_W-1:0] conv_cycles;
    logic [ctb_pkg::COMP_W-1:0] conv_comp, first_comp;
    logic signed [ctb_pkg::TICK_W-1:0] conv_ticks;
    ctb_pkg::ctb_status_t status;
    logic [11:0] on_e;
    logic sld_e, mh_e, ml_e, comp_pend, in_comp;
    int avg [12];
    int pos_e, nconv, last_sel, ncomp;
    int err_total = 0;
    int num_checks = 0;

    always #50 clk = ~clk;

    ctb_proc dut (.clk(clk), .rst_n(rst_n), .scan_start(scan_start),
        .cfg_wr(cfg_wr), .cfg_in(cfg_in), .host_run(host_run),
        .host_comp_req(host_comp_req), .irq_clear(irq_clear),
        .conv_start(conv_start), .conv_sel(conv_sel),
        .conv_cycles(conv_cycles), .conv_comp(conv_comp),
        .conv_done(conv_done), .conv_ticks(conv_ticks), .status(status),
        .scan_done(scan_done), .comp_done(comp_done),
        .scan_busy(scan_busy), .irq_out_n(irq_out_n));
    ctb_conv_model u_conv (.clk(clk), .slow(slow), .touch(touch),
        .conv_start(conv_start), .conv_sel(conv_sel), .conv_comp(conv_comp),
        .conv_done(conv_done), .conv_ticks(conv_ticks));

    task automatic chk(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask

    always @(negedge clk) begin
        if (conv_start) begin
            chk("conv_sel", cfg_in.sense_en[conv_sel] && conv_sel >= last_sel,
                1);
            chk("conv_cycles", conv_cycles, cfg_in.sens[conv_sel]);
            if (!in_comp) begin
                chk("conv_comp", conv_comp,
                    16'h02ff + {conv_sel, 4'h0});
            end
            if (nconv == 0) begin
                first_comp = conv_comp;
            end
            last_sel = conv_sel;
            nconv++;
        end
    end

    // Reference filter, hysteresis and centre-of-gravity of one scan.
    task automatic model();
        int sw, sd, rk, raw, d, th, hy, pp;
        logic so;
        sw = 0;
        sd = 0;
        rk = 0;
        pp = pos_e;
        so = sld_e;
        for (int i = 0; i < 12; i++) begin
            if (cfg_in.sense_en[i]) begin
                raw = 1 + touch[i];
                avg[i] += (raw - avg[i]) >>> 3;
                d = raw - avg[i];
                th = cfg_in.prox_mask[i] ? cfg_in.prox_thr : cfg_in.thr;
                hy = cfg_in.prox_mask[i] ? cfg_in.prox_hys : cfg_in.hys;
                if (d >= th + hy) begin
                    on_e[i] = 1'b1;
                end else if (d < th - hy) begin
                    on_e[i] = 1'b0;
                end
                if (avg[i] > int'(cfg_in.noise_pos) ||
                    avg[i] < -int'(cfg_in.noise_neg)) begin
                    comp_pend = 1'b1;
                end
                if (cfg_in.slider_mask[i]) begin
                    sw += (d > 0) ? d * rk : 0;
                    sd += (d > 0) ? d : 0;
                    rk++;
                end
            end
        end
        sld_e = |(on_e & cfg_in.slider_mask & cfg_in.sense_en);
        if (sld_e && sd > 0 && rk > 1) begin
            pos_e = sw * int'(cfg_in.slider_max) / (sd * (rk - 1));
        end
        mh_e = sld_e && so && pos_e - pp >= int'(cfg_in.step);
        ml_e = sld_e && so && pp - pos_e >= int'(cfg_in.step);
    endtask

    task automatic do_scan(input bit judge);
        int n;
        in_comp = comp_pend | !judge;
        nconv = 0;
        last_sel = 0;
        pulse(scan_start);
        for (n = 0; n < 4000 && !(scan_done || comp_done); n++) begin
            @(negedge clk);
        end
        if (n == 4000) begin
            chk("scan end", 0, 1);
            report_and_stop();
        end
        if (judge) begin
            chk("comp_done", comp_done, in_comp);
        end
        if (comp_done) begin
            comp_pend = 1'b0;
            ncomp++;
            foreach (avg[i]) avg[i] = 0;
        end else if (judge) begin
            model();
            chk("buttons", status.button_on & ~cfg_in.slider_mask,
                on_e & ~cfg_in.slider_mask);
            chk("slider_on", status.slider_on, sld_e);
            chk("slider_pos", status.slider_pos, pos_e);
            chk("move_high", status.move_high, mh_e);
            chk("move_low", status.move_low, ml_e);
        end
    endtask

    task automatic do_reset();
        rst_n = 1'b0;
        cfg_in = ctb_pkg::CFG_DEFAULT;
        on_e = '0;
        sld_e = 1'b0;
        pos_e = 0;
        comp_pend = 1'b1;
        foreach (avg[i]) avg[i] = 0;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
    endtask

    task automatic t_powerup();
        do_scan(1'b1);
        chk("power-up comp", comp_done, 1);
        chk("irq low", irq_out_n, 0);
        chk("first trial", first_comp, 16'h8000);
        pulse(irq_clear);
        chk("irq released", irq_out_n, 1);
        do_scan(1'b1);
        chk("inputs scanned", nconv, 12);
    endtask

    task automatic t_touch();
        int seq [5] = '{200, 130, 0, 140, 0};
        int prx [3] = '{40, 35, 0};
        int sld [6] = '{12'h040, 12'h800, 12'h040, 12'h300, 12'h300, 0};
        foreach (seq[k]) begin
            touch[0] = 16'(seq[k]);
            do_scan(1'b1);
        end
        cfg_in.prox_mask = 12'h002;
        pulse(cfg_wr);
        foreach (prx[k]) begin
            touch[1] = 16'(prx[k]);
            do_scan(1'b1);
        end
        foreach (sld[k]) begin
            for (int i = 6; i < 12; i++) begin
                touch[i] = sld[k][i] ? 16'h00c8 : 16'h0000;
            end
            touch[9] = (k == 4) ? 16'h00e6 : touch[9];
            do_scan(1'b1);
        end
    endtask

    task automatic t_comp();
        touch[3] = 16'h00fa;
        for (int k = 0; k < 8 && !comp_pend; k++) begin
            do_scan(1'b1);
        end
        touch[3] = 16'h0000;
        chk("drift seen", comp_pend, 1);
        do_scan(1'b1);
        pulse(irq_clear);
        host_run = 1'b0;
        pulse(host_comp_req);
        do_scan(1'b1);
        host_run = 1'b1;
        pulse(host_comp_req);
        comp_pend = 1'b1;
        do_scan(1'b1);
        pulse(irq_clear);
    endtask

    task automatic t_skip();
        cfg_in.sense_en = 12'h845;
        for (int i = 0; i < 12; i++) begin
            cfg_in.sens[i] = 3'(i);
        end
        pulse(cfg_wr);
        slow = 1'b1;
        do_scan(1'b1);
        chk("enabled count", nconv, 4);
        pulse(host_comp_req);
        comp_pend = 1'b1;
        do_scan(1'b1);
        slow = 1'b0;
        do_reset();
        do_scan(1'b1);
        chk("trial after reset", first_comp, 16'h8000);
        cfg_in.comp_period = 16'h0002;
        pulse(cfg_wr);
        ncomp = 0;
        repeat (5) do_scan(1'b0);
        chk("periodic comp", ncomp, 1);
    endtask

    initial begin
        do_reset();
        t_powerup();
        t_touch();
        t_comp();
        t_skip();
        report_and_stop();
    end
endmodule // tb

bind ctb_proc ctb_chk u_chk (.clk(clk), .rst_n(rst_n), .scan_start(scan_start),
    .irq_clear(irq_clear), .conv_start(conv_start), .status(status),
    .scan_done(scan_done), .comp_done(comp_done), .scan_busy(scan_busy),
    .irq_out_n(irq_out_n));
